// [hw/ira_defs.svh]
// Constants of the indirect register access port.
// Assumes a 50 MHz core clock and a 32-bit APB register bus.
//
// Summary of operation
// RL1: Data then address write stores at update.
// RL2: Address-only write reads location at update.
// RL3: Data word as two byte registers, reset zero.
// RL4: Eight-bit address register selects internal location.
// RL5: Status bit 0 shows access still pending.
// RL6: Status bits 7:1 read zero, reset zero.
// RL7: Completion sets serviced flag, write-one clears.
// RL8: Enable bit gates serviced flag onto interrupt.
// RL9: Software waits for completion before next access.
`ifndef IRA_DEFS_SVH
`define IRA_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IRA_CLK_PERIOD_NS 20
`define IRA_UPDATE_PERIOD_NS 62500
`define IRA_UPDATE_CYCLES (`IRA_UPDATE_PERIOD_NS / `IRA_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IRA_IDX_DATA_LO 8'h1C
`define IRA_IDX_DATA_HI 8'h1D
`define IRA_IDX_ADDR 8'h1E
`define IRA_IDX_STATUS 8'h1F
`define IRA_IDX_IRQ_STAT 8'h14
`define IRA_IDX_IRQ_EN 8'h17

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define IRA_PENDING_BIT 0
`define IRA_SERVICED_BIT 1
`define IRA_DATA_RST 16'h0000
`define IRA_ADDR_RST 8'h00
`define IRA_FLAG_RST 1'b0

`endif

// [hw/ira_pkg.sv]
// Types of the indirect register access port.
// Assumes ira_defs.svh supplies the numeric constants.
package ira_pkg;

  // Queued access state, Gray along idle to write or read
  typedef enum logic [1:0] {
    IRA_IDLE = 2'b00,
    IRA_WRITE = 2'b01,
    IRA_READ = 2'b10
  } ira_state_t;

endpackage : ira_pkg

// [hw/ira_update_tick.sv]
// Divider giving the one-cycle indirect update enable.
// Assumes one core clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`include "ira_defs.svh"

module ira_update_tick #(
  parameter int DIV = `IRA_UPDATE_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Update enable
  output logic TICK
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic tick_reg;
  wire at_last = (cnt_reg == LAST);

  // Wrapping count
  assign cnt_next = at_last ? '0 : cnt_reg + CW'(1);

  // Count and registered pulse
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= at_last;
    end
  end

  assign TICK = tick_reg;

endmodule : ira_update_tick

// [hw/ira_top.sv]
// Indirect register access port with APB slave and interrupt.
// Assumes an APB master on CLK; no wait states, PSLVERR on
// unmapped or unaligned addresses.
`timescale 1ns/1ns
`include "ira_defs.svh"

module ira_top
  import ira_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int LOC_W = 8,
  parameter int WORD_W = 16,
  parameter int UPDATE_DIV = `IRA_UPDATE_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interrupt
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Word hit for a register index
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] idx);
    reg_hit = (a[ADDR_W-1:2] == idx[ADDR_W-3:0]) && (a[1:0] == 2'b00);
  endfunction : reg_hit

  wire hit_data_lo = reg_hit(PADDR, `IRA_IDX_DATA_LO);
  wire hit_data_hi = reg_hit(PADDR, `IRA_IDX_DATA_HI);
  wire hit_addr = reg_hit(PADDR, `IRA_IDX_ADDR);
  wire hit_status = reg_hit(PADDR, `IRA_IDX_STATUS);
  wire hit_irq_stat = reg_hit(PADDR, `IRA_IDX_IRQ_STAT);
  wire hit_irq_en = reg_hit(PADDR, `IRA_IDX_IRQ_EN);
  wire mapped = hit_data_lo | hit_data_hi | hit_addr | hit_status
                | hit_irq_stat | hit_irq_en;

  // Bus phases
  wire setup_ph = PSEL & ~PENABLE;
  wire access_ph = PSEL & PENABLE;
  wire wr_ok = access_ph & PWRITE & mapped;
  wire wr_data_lo = wr_ok & hit_data_lo;
  wire wr_data_hi = wr_ok & hit_data_hi;
  wire wr_addr = wr_ok & hit_addr;
  wire wr_irq_stat = wr_ok & hit_irq_stat;
  wire wr_irq_en = wr_ok & hit_irq_en;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] data_word_reg;
  logic [WORD_W-1:0] data_word_next;
  logic [LOC_W-1:0] loc_sel_reg;
  ira_state_t state_reg;
  ira_state_t state_next;
  logic data_loaded_reg;
  logic data_loaded_next;
  logic serviced_reg;
  logic serviced_next;
  logic irq_en_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;
  logic [WORD_W-1:0] mem [0:(1<<LOC_W)-1];
  logic tick;

  wire pending = (state_reg != IRA_IDLE);
  wire service = tick & pending;
  wire [WORD_W-1:0] mem_rd_word = mem[loc_sel_reg];

  // ----------------------------------------------------------------
  // Indirect update enable
  // ----------------------------------------------------------------
  ira_update_tick #(
    .DIV(UPDATE_DIV)
  ) u_tick (
    .CLK(CLK),
    .RST_B(RST_B),
    .TICK(tick)
  );

  // ----------------------------------------------------------------
  // Queue control
  // ----------------------------------------------------------------

  // Address write queues write if data came first, else read
  always_comb begin
    state_next = state_reg;
    data_loaded_next = data_loaded_reg | wr_data_lo | wr_data_hi;
    unique case (state_reg)
      IRA_IDLE, IRA_WRITE, IRA_READ: begin
        if (service) begin
          state_next = IRA_IDLE;
        end
      end
      default: begin
        state_next = IRA_IDLE;
      end
    endcase
    if (wr_addr) begin
      state_next = data_loaded_next ? IRA_WRITE : IRA_READ; // RL1 RL2
      data_loaded_next = 1'b0;
    end
  end

  // Data word: bus byte writes, read result at update
  always_comb begin
    data_word_next = data_word_reg;
    if (service && state_reg == IRA_READ) begin
      data_word_next = mem_rd_word; // RL2
    end
    if (wr_data_lo) begin
      data_word_next[7:0] = PWDATA[7:0]; // RL3
    end
    if (wr_data_hi) begin
      data_word_next[15:8] = PWDATA[7:0]; // RL3
    end
  end

  // Serviced flag: completion set wins over write-one clear
  assign serviced_next = service
                         | (serviced_reg & ~(wr_irq_stat & PWDATA[`IRA_SERVICED_BIT])); // RL7

  // Control registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= IRA_IDLE;
      data_loaded_reg <= `IRA_FLAG_RST;
      data_word_reg <= `IRA_DATA_RST; // RL3
      serviced_reg <= `IRA_FLAG_RST;
      irq_en_reg <= `IRA_FLAG_RST;
    end else begin
      state_reg <= state_next;
      data_loaded_reg <= data_loaded_next;
      data_word_reg <= data_word_next;
      serviced_reg <= serviced_next;
      if (wr_irq_en) begin
        irq_en_reg <= PWDATA[`IRA_SERVICED_BIT]; // RL8
      end
    end
  end

  // Location select register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      loc_sel_reg <= `IRA_ADDR_RST;
    end else if (wr_addr) begin
      loc_sel_reg <= PWDATA[LOC_W-1:0]; // RL4
    end
  end

  // ----------------------------------------------------------------
  // Internal parameter memory
  // ----------------------------------------------------------------

  // Store queued word at update
  always_ff @(posedge CLK) begin
    if (service && state_reg == IRA_WRITE) begin
      mem[loc_sel_reg] <= data_word_reg; // RL1
    end
  end

  // ----------------------------------------------------------------
  // Read path and bus answer
  // ----------------------------------------------------------------

  // Read mux, unused bits zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_data_lo) begin
      rd_mux[7:0] = data_word_reg[7:0]; // RL3
    end
    if (hit_data_hi) begin
      rd_mux[7:0] = data_word_reg[15:8]; // RL3
    end
    if (hit_addr) begin
      rd_mux[LOC_W-1:0] = loc_sel_reg; // RL4
    end
    if (hit_status) begin
      rd_mux[`IRA_PENDING_BIT] = pending; // RL5 RL6
    end
    if (hit_irq_stat) begin
      rd_mux[`IRA_SERVICED_BIT] = serviced_reg;
    end
    if (hit_irq_en) begin
      rd_mux[`IRA_SERVICED_BIT] = irq_en_reg;
    end
  end

  // Read data captured in setup phase
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_reg <= PWRITE ? 32'h0000_0000 : rd_mux;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = access_ph & ~mapped;
  assign IRQ = serviced_reg & irq_en_reg; // RL8

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  property p_write_store;
    (service && state_reg == IRA_WRITE) |=> (mem[$past(loc_sel_reg)] == $past(data_word_reg));
  endproperty
  a_write_store: assert property (p_write_store) // RL1
    else $error("queued write not stored at update");

  property p_read_load;
    (service && state_reg == IRA_READ && !wr_data_lo && !wr_data_hi)
      |=> (data_word_reg == $past(mem_rd_word));
  endproperty
  a_read_load: assert property (p_read_load) // RL2
    else $error("queued read not loaded at update");

  property p_data_hi_read;
    (setup_ph && !PWRITE && hit_data_hi)
      |=> (PRDATA == {24'h00_0000, $past(data_word_reg[15:8])});
  endproperty
  a_data_hi_read: assert property (p_data_hi_read) // RL3
    else $error("high data byte read wrong");

  property p_addr_queue;
    wr_addr |=> (state_reg != IRA_IDLE) && (loc_sel_reg == $past(PWDATA[LOC_W-1:0]));
  endproperty
  a_addr_queue: assert property (p_addr_queue) // RL4
    else $error("address write did not queue access");

  property p_pending_read;
    (setup_ph && !PWRITE && hit_status) |=> (PRDATA[`IRA_PENDING_BIT] == $past(pending));
  endproperty
  a_pending_read: assert property (p_pending_read) // RL5
    else $error("pending bit read wrong");

  property p_status_reserved;
    (setup_ph && !PWRITE && hit_status) |=> (PRDATA[31:1] == 31'h0000_0000);
  endproperty
  a_status_reserved: assert property (p_status_reserved) // RL6
    else $error("status reserved bits not zero");

  property p_serviced_set;
    service |=> serviced_reg && !pending ##1 (serviced_reg || $past(wr_irq_stat));
  endproperty
  a_serviced_set: assert property (p_serviced_set) // RL7
    else $error("completion did not set serviced flag");

  property p_irq_gate;
    (serviced_reg && !irq_en_reg) |-> !IRQ
      ##1 (!$past(wr_irq_en)
           || (IRQ == (serviced_reg && $past(PWDATA[`IRA_SERVICED_BIT]))));
  endproperty
  a_irq_gate: assert property (p_irq_gate) // RL8
    else $error("interrupt not gated by enable");

  // Cycles a queued access has waited since it was queued or since the last update, whichever is later
  logic [31:0] wait_cnt_reg;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wait_cnt_reg <= 32'h0000_0000;
    end else if (!pending || service) begin
      wait_cnt_reg <= 32'h0000_0000;
    end else begin
      wait_cnt_reg <= wait_cnt_reg + 32'h0000_0001;
    end
  end

  property p_pending_bound;
    pending |-> (wait_cnt_reg < 32'(UPDATE_DIV));
  endproperty
  a_pending_bound: assert property (p_pending_bound) // RL5
    else $error("pending access not serviced in one update period");

endmodule : ira_top

// [verification/ira_host_model.sv]
// Host software model: APB master that reaches the port's registers.
// Assumes one clock, a slave that answers with PREADY in time.
`timescale 1ns/1ns

module ira_host_model (
  // Clock
  input wire logic CLK,
  // APB master side
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [7:0] PADDR,
  output logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  // ----------------------------------------
  // Bus transfer
  // ----------------------------------------
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
  end

  // One setup cycle, then access until PREADY is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : xfer

  // Poll the pending bit until the access is serviced
  task automatic wait_done();
    logic [31:0] r;
    logic e;
    do begin
      xfer(1'b0, 8'h7C, 32'h0, r, e);
    end while (r[0] !== 1'b0);
  endtask : wait_done
endmodule : ira_host_model

// [verification/indirect_register_access_port_test.sv]
// Self-checking bench of the indirect register access port.
// Assumes ira_top with a shortened update divider.
`timescale 1ns/1ns

module indirect_register_access_port_test;
  logic CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, err;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  int miscompares = 0;
  int n_checks = 0;
  logic [15:0] lf = 16'h5C4C;
  logic [15:0] dat [4];
  logic [7:0] loc [4];

  // ----------------------------------------
  // Clock, design and host
  // ----------------------------------------
  initial CLK = 1'b0;
  always #10 CLK = ~CLK;

  ira_top #(.UPDATE_DIV(64)) uut (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));

  ira_host_model host (.CLK(CLK), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, rd, err);
    chk(rd, exp, "read data");
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
  endtask : wr

  task automatic irq_chk(input logic exp);
    #1;
    chk({31'h0, IRQ}, {31'h0, exp}, "irq level");
  endtask : irq_chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Watchdog against a hung handshake
  initial begin
    #1000000;
    miscompares++;
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    RST_B = 1'b0;
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    rd_chk(8'h70, 32'h0);
    rd_chk(8'h74, 32'h0);
    rd_chk(8'h7C, 32'h0);
    rd_chk(8'h50, 32'h0);
    irq_chk(1'b0);
    $display("test reset done");
    wr(8'h5C, 32'h2);
    wr(8'h70, 32'h0);
    wr(8'h78, 32'h0);
    host.wait_done();
    wr(8'h50, 32'h2);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr_next(lf);
      dat[i] = lf;
      lf = lfsr_next(lf);
      loc[i] = {lf[5:0], i[1:0]};
      wr(8'h70, {24'h0, dat[i][7:0]});
      wr(8'h74, {24'h0, dat[i][15:8]});
      wr(8'h78, {24'h0, loc[i]});
      rd_chk(8'h7C, 32'h1);
      host.wait_done();
      irq_chk(1'b1);
      rd_chk(8'h50, 32'h2);
      wr(8'h50, 32'h2);
      irq_chk(1'b0);
      rd_chk(8'h78, {24'h0, loc[i]});
    end
    $display("test write done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h78, {24'h0, loc[i]});
      host.wait_done();
      rd_chk(8'h70, {24'h0, dat[i][7:0]});
      rd_chk(8'h74, {24'h0, dat[i][15:8]});
      wr(8'h50, 32'h2);
    end
    $display("test read back done");
    wr(8'h5C, 32'h0);
    wr(8'h78, {24'h0, loc[1]});
    host.wait_done();
    irq_chk(1'b0);
    rd_chk(8'h50, 32'h2);
    wr(8'h5C, 32'h2);
    irq_chk(1'b1);
    $display("test mask done");
    host.xfer(1'b0, 8'h00, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1, "unmapped error");
    host.xfer(1'b0, 8'h71, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1, "unaligned error");
    wr(8'h7C, 32'hFF);
    rd_chk(8'h7C, 32'h0);
    $display("test refusal done");
    end_of_test();
  end
endmodule : indirect_register_access_port_test
